// File: verilog/fosr_pkg.sv
// Package for the flash operation status register: bit positions, codes, carriers
package fosr_pkg;
  // Status bit positions
  localparam int unsigned BIT_READY = 7;
  localparam int unsigned BIT_ERS_SUSP = 6;
  localparam int unsigned BIT_ERS_FAIL = 5;
  localparam int unsigned BIT_PGM_FAIL = 4;
  localparam int unsigned BIT_SUPPLY_FAULT = 3;
  localparam int unsigned BIT_PGM_SUSP = 2;
  localparam int unsigned BIT_PROT_VIOL = 1;
  localparam int unsigned BIT_RESERVED = 0;
  localparam int unsigned STATUS_W = 8;
  localparam logic [7:0] STATUS_RESET = 8'h80;
  localparam logic RESERVED_VALUE = 1'b0;

  // Command events, delivered by the command decoder as one-cycle strobes
  typedef struct packed {
    logic clear_status;
    logic start_program;
    logic start_erase;
    logic suspend;
    logic resume;
  } fosr_cmd_t;

  // Outcome reports from the program/erase algorithm, one-cycle strobes
  typedef struct packed {
    logic done;
    logic verify_fail;
    logic paused;
  } fosr_alg_t;

  typedef enum logic [3:0] {
    FOSR_IDLE = 4'b0001,
    FOSR_PGM = 4'b0010,
    FOSR_ERS = 4'b0100,
    FOSR_SUSP = 4'b1000
  } fosr_state_t;

  typedef struct packed {
    fosr_state_t st;
    logic susp_req;
    logic susp_is_erase;
    logic pgm_in_erase;
    logic ers_susp;
    logic ers_fail;
    logic pgm_fail;
    logic supply_fault;
    logic pgm_susp;
    logic prot_viol;
    logic [7:0] rd_data;
    logic vpp_s1;
    logic vpp_s2;
  } fosr_regs_t;
endpackage : fosr_pkg

// File: verilog/fosr_status.sv
// Flash operation status register with its program/erase tracking state
`timescale 1ns/1ps
`default_nettype none
module fosr_status
  import fosr_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clk_en,
  // Command decoder strobes
  input wire fosr_pkg::fosr_cmd_t cmd,
  input wire logic target_protected,
  // Fast programming supply comparator, asynchronous pin level
  input wire logic supply_ok_pin,
  // Program/erase algorithm handshake
  input wire fosr_pkg::fosr_alg_t alg,
  output logic alg_run,
  output logic alg_erase,
  output logic alg_pause_req,
  // Read path
  input wire logic status_read,
  output logic [7:0] data_io_low_byte,
  output logic [7:0] operation_status
);
  import fosr_pkg::*;

  fosr_regs_t r_q;
  fosr_regs_t r_d;
  logic errors_set;
  logic supply_ok;
  logic busy;
  logic [7:0] status;

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  // A named bit outside the byte would silently vanish from every read
  if (BIT_READY >= STATUS_W || BIT_RESERVED >= STATUS_W)
  begin : g_bad_layout
    $error("status bit positions exceed the status width");
  end
  if (STATUS_W != $bits(operation_status))
  begin : g_bad_width
    $error("status width does not match the status ports");
  end

  // ----------------------------------------------------------------
  // Decoding helpers
  // ----------------------------------------------------------------
  // Controller counts as active only while it runs a program or an erase
  function automatic logic state_busy(input fosr_state_t s);
    state_busy = (s == FOSR_PGM) || (s == FOSR_ERS);
  endfunction : state_busy

  // From idle or suspend, starts are refused only while a program sits suspended; busy states ignore them
  function automatic logic start_allowed(input fosr_state_t s, input logic susp_erase);
    start_allowed = !(s == FOSR_SUSP && !susp_erase);
  endfunction : start_allowed

  // Any sticky error that would make a new operation read as failed
  function automatic logic any_error(input fosr_regs_t r);
    any_error = r.ers_fail | r.pgm_fail | r.supply_fault | r.prot_viol;
  endfunction : any_error

  // ----------------------------------------------------------------
  // Status assembly
  // ----------------------------------------------------------------
  assign errors_set = any_error(r_q);
  assign supply_ok = r_q.vpp_s2;
  assign busy = state_busy(r_q.st);

  always_comb
  begin
    status = '0;
    status[BIT_READY] = ~busy;
    status[BIT_ERS_SUSP] = r_q.ers_susp;
    status[BIT_ERS_FAIL] = r_q.ers_fail;
    status[BIT_PGM_FAIL] = r_q.pgm_fail;
    status[BIT_SUPPLY_FAULT] = r_q.supply_fault;
    status[BIT_PGM_SUSP] = r_q.pgm_susp;
    status[BIT_PROT_VIOL] = r_q.prot_viol;
    status[BIT_RESERVED] = RESERVED_VALUE;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign operation_status = status;
  // Latched on each read strobe; no address takes part
  assign data_io_low_byte = r_q.rd_data;
  // Handshake outputs decode straight from the state register
  assign alg_run = busy;
  assign alg_erase = (r_q.st == FOSR_ERS);
  assign alg_pause_req = r_q.susp_req;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    r_d = r_q;
    // Two flops on the pin; only the second one feeds any logic
    r_d.vpp_s1 = supply_ok_pin;
    r_d.vpp_s2 = r_q.vpp_s1;
    if (cmd.clear_status)
    begin
      // Ready and suspend bits are left alone
      r_d.ers_fail = 1'b0;
      r_d.pgm_fail = 1'b0;
      r_d.supply_fault = 1'b0;
      r_d.prot_viol = 1'b0;
    end
    // Set terms come after the clear, so a set in the same cycle wins
    case (r_q.st)
      FOSR_IDLE, FOSR_SUSP:
      begin
        if ((cmd.start_program || cmd.start_erase) && start_allowed(r_q.st, r_q.susp_is_erase))
        begin
          // Leftover errors not cleared in the same cycle make the new operation read as failed; only a
          // fresh start checks the supply, never mid-operation
          if (!supply_ok)
            r_d.supply_fault = 1'b1;
          else if (target_protected)
            r_d.prot_viol = 1'b1;
          else if (errors_set && !cmd.clear_status)
          begin
            if (cmd.start_program)
              r_d.pgm_fail = 1'b1;
            else
              r_d.ers_fail = 1'b1;
          end
          else
          begin
            r_d.st = cmd.start_program ? FOSR_PGM : FOSR_ERS;
            r_d.pgm_in_erase = (r_q.st == FOSR_SUSP);
            r_d.susp_req = 1'b0;
          end
        end
        else if (cmd.resume && r_q.st == FOSR_SUSP)
        begin
          r_d.st = r_q.susp_is_erase ? FOSR_ERS : FOSR_PGM;
          r_d.ers_susp = 1'b0;
          r_d.pgm_susp = 1'b0;
        end
      end
      FOSR_PGM, FOSR_ERS:
      begin
        if (cmd.suspend)
          r_d.susp_req = 1'b1;
        // Results land in the same edge that raises ready
        if (alg.done)
        begin
          r_d.susp_req = 1'b0;
          if (alg.verify_fail)
          begin
            if (r_q.st == FOSR_PGM)
              r_d.pgm_fail = 1'b1;
            else
              r_d.ers_fail = 1'b1;
          end
          // A program run inside a suspended erase returns to that suspend
          r_d.st = r_q.pgm_in_erase ? FOSR_SUSP : FOSR_IDLE;
          r_d.pgm_in_erase = 1'b0;
        end
        else if (alg.paused && r_q.susp_req && !r_q.pgm_in_erase)
        begin
          r_d.susp_req = 1'b0;
          r_d.st = FOSR_SUSP;
          r_d.susp_is_erase = (r_q.st == FOSR_ERS);
          r_d.ers_susp = (r_q.st == FOSR_ERS);
          r_d.pgm_susp = (r_q.st == FOSR_PGM);
        end
      end
      default:
      begin
        // Illegal codes fall back to idle rather than lock up
        r_d.st = FOSR_IDLE;
      end
    endcase
    // Capture shows the status of this cycle, before the edge updates it
    if (status_read)
      r_d.rd_data = status;
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // A low enable freezes every bit, the supply synchroniser included
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      r_q <= '{st: FOSR_IDLE, rd_data: STATUS_RESET, default: '0};
    end
    else if (clk_en)
    begin
      r_q <= r_d;
    end
  end
endmodule : fosr_status
`default_nettype wire

// File: verif/fosr_alg_model.sv
// Program/erase algorithm stand-in answering the status block
`timescale 1ns/1ps
`default_nettype none
module fosr_alg_model
  import fosr_pkg::*;
(
  // Status block handshake
  input wire logic clk,
  input wire logic rst_b,
  input wire logic run,
  input wire logic preq,
  input wire logic fail,
  output var fosr_pkg::fosr_alg_t alg
);
  logic [2:0] n;
  // Count holds its value across a pause, so a resumed job ends sooner
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
      {n, alg} <= '0;
    else
    begin
      n <= run ? n + 3'h1 : n;
      alg <= '0;
      if (run && alg == '0)
        alg <= preq ? 3'b001 : (n == 3'h5 ? {1'b1, fail, 1'b0} : 3'b000);
    end
endmodule : fosr_alg_model
`default_nettype wire

// File: verif/fosr_props.sv
// Concurrent checks on the status block ports
`timescale 1ns/1ps
`default_nettype none
module fosr_props
  import fosr_pkg::*;
(
  // Watched design ports
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire fosr_pkg::fosr_cmd_t cmd,
  input wire fosr_pkg::fosr_alg_t alg,
  input wire logic alg_run,
  input wire logic alg_erase,
  input wire logic status_read,
  input wire logic [7:0] data_io_low_byte,
  input wire logic [7:0] operation_status
);
  wire [7:0] s = operation_status;
  wire clr = clk_en && cmd.clear_status;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  chk_rsv_zero: assert property (!s[0]) else $error("bit 0 set");
  chk_ready_busy: assert property (clk_en && alg_run && alg.done |=> s[7])
    else $error("ready");
  chk_pgm_fail: assert property (clk_en && alg_run && !alg_erase
    && alg.done && alg.verify_fail |=> s[4]) else $error("pgm fail");
  chk_pgm_hold: assert property (s[4] && !clr |=> s[4]) else $error("bit 4");
  chk_sup_hold: assert property (s[3] && !clr |=> s[3]) else $error("bit 3");
  chk_prot_hold: assert property (s[1] && !clr |=> s[1]) else $error("bit 1");
  chk_clear_all: assert property (clk_en && cmd == 5'h10 && alg == '0
    |=> (s & 8'h3a) == 8'h00 && s[7:6] == $past(s[7:6]) && s[2] == $past(s[2]))
    else $error("clear");
  chk_resume_bit: assert property (clk_en && cmd.resume && s[2] |=> !s[2] && !s[7])
    else $error("resume");
  chk_read_path: assert property (clk_en && status_read |=> data_io_low_byte == $past(s))
    else $error("read");
  cover property (s[4]);
  cover property (s[2]);
  cover property (s[6]);
endmodule : fosr_props
`default_nettype wire

// File: verif/fosr_status_tb.sv
// Self-checking bench for the flash operation status register
`timescale 1ns/1ps
`default_nettype none
module fosr_status_tb;
  import fosr_pkg::*;
  logic clk = 0;
  logic rst_b = 0;
  logic prot = 0;
  logic sup = 1;
  logic rd = 0;
  logic en = 1;
  logic vf = 0;
  fosr_cmd_t cmd = '0;
  fosr_alg_t alg;
  logic run, ers, preq;
  logic [7:0] st, dio;
  int fail_count = 0;
  int check_count = 0;
  // Row: erase, verify fail, protected, supply bad, expected status
  logic [11:0] rows [5] = '{12'h080, 12'h490, 12'hca0, 12'h282, 12'h188};
  fosr_status DUT (.clk, .rst_b, .clk_en(en), .cmd, .target_protected(prot),
    .supply_ok_pin(sup), .alg, .alg_run(run), .alg_erase(ers), .alg_pause_req(preq),
    .status_read(rd), .data_io_low_byte(dio), .operation_status(st));
  fosr_alg_model PE (.clk, .rst_b, .run, .preq, .fail(vf), .alg);
  initial forever #2 clk = ~clk;
  task tick; @(posedge clk) #1; endtask : tick
  task chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  // Leaves an idle cycle before each strobe so no signal is set twice at once
  task strobe(input fosr_cmd_t c);
    tick;
    cmd = c;
    tick;
    cmd = '0;
  endtask : strobe
  task wait_rdy;
    repeat (2) tick;
    for (int i = 0; i < 40 && st[7] !== 1'b1; i++) tick;
  endtask : wait_rdy
  task tally_and_finish;
    if (fail_count == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : tally_and_finish
  initial
  begin
    repeat (5) @(posedge clk);
    #1 rst_b = 1;
    chk(st, 8'h80);
    foreach (rows[i])
    begin
      {vf, prot, sup} = {rows[i][10:9], !rows[i][8]};
      repeat (3) tick;
      strobe(rows[i][11] ? 5'h14 : 5'h18);
      wait_rdy;
      chk(st, rows[i][7:0]);
    end
    {vf, prot, sup} = 3'b001;
    repeat (3) tick;
    strobe(5'h08);
    wait_rdy;
    chk(st, 8'h98);
    rd = 1;
    tick;
    rd = 0;
    chk(dio, 8'h98);
    strobe(5'h10);
    chk(st, 8'h80);
    en = 0;
    strobe(5'h08);
    chk(st, 8'h80);
    en = 1;
    for (int e = 0; e < 2; e++)
    begin
      strobe(e ? 5'h04 : 5'h08);
      chk({6'h00, run, ers}, e ? 8'h03 : 8'h02);
      strobe(5'h02);
      wait_rdy;
      chk(st, e ? 8'hc0 : 8'h84);
      if (e)
      begin
        strobe(5'h08);
        chk({6'h00, run, ers}, 8'h02);
        wait_rdy;
        chk(st, 8'hc0);
      end
      strobe(5'h01);
      chk(st & 8'hc4, 8'h00);
      wait_rdy;
      chk(st, 8'h80);
    end
    strobe(5'h08);
    rst_b = 0;
    tick;
    chk(st, 8'h80);
    chk(dio, 8'h80);
    rst_b = 1;
    repeat (3) tick;
    strobe(5'h08);
    wait_rdy;
    chk(st, 8'h80);
    tally_and_finish;
  end
  initial
  begin
    repeat (1000) @(posedge clk);
    fail_count++;
    tally_and_finish;
  end
endmodule : fosr_status_tb
bind fosr_status fosr_props CHK (.clk, .rst_b, .clk_en, .cmd, .alg, .alg_run, .alg_erase,
  .status_read, .data_io_low_byte, .operation_status);
`default_nettype wire
